// [verilog/gpt_pkg.sv]
// constants, field layout and timing figures of the 16-bit timer/counter
// assumes a single 50 MHz system clock and a classic wishbone register bus
package gpt_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] GPT_OFS_COUNT   = 4'h0;  // count_value
    localparam logic [3:0] GPT_OFS_PERIOD  = 4'h4;  // period_value
    localparam logic [3:0] GPT_OFS_CONTROL = 4'h8;  // timer_control
    localparam logic [3:0] GPT_OFS_INT     = 4'hc;  // flag and enable

    // ------------------------------------------------------------
    // timer_control field positions
    // ------------------------------------------------------------
    localparam int GPT_BIT_ON    = 15;              // count_enable
    localparam int GPT_BIT_SIDL  = 13;              // idle_stop
    localparam int GPT_BIT_GATE  = 6;               // gate_accumulate_enable
    localparam int GPT_BIT_PS_HI = 5;               // prescale_select msb
    localparam int GPT_BIT_PS_LO = 4;               // prescale_select lsb
    localparam int GPT_BIT_SYNC  = 2;               // ext_clock_sync
    localparam int GPT_BIT_CS    = 1;               // clock_source_select

    // interrupt register field positions
    localparam int GPT_BIT_IF    = 0;               // period_int_flag
    localparam int GPT_BIT_IE    = 1;               // period_int_enable

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [15:0] GPT_RST_COUNT   = 16'h0000;
    localparam logic [15:0] GPT_RST_PERIOD  = 16'hffff;
    localparam logic [15:0] GPT_RST_CONTROL = 16'h0000;
    localparam logic [15:0] GPT_CTRL_MASK   = 16'ha076; // writable control bits

    // prescale encodings: ratios 1, 8, 64, 256 as terminal counts
    localparam logic [7:0] GPT_PS_TC_1   = 8'h00;
    localparam logic [7:0] GPT_PS_TC_8   = 8'h07;
    localparam logic [7:0] GPT_PS_TC_64  = 8'h3f;
    localparam logic [7:0] GPT_PS_TC_256 = 8'hff;

    // operating modes of the counting source
    typedef enum logic [1:0] {
        GPT_SRC_TIMER,
        GPT_SRC_GATED,
        GPT_SRC_SYNC,
        GPT_SRC_ASYNC
    } gpt_src_t;

endpackage

// [verilog/gpt_sync2.sv]
// two flip-flop synchroniser for one level
// assumes the input is asynchronous to clk_i
`timescale 1ns/10ps
`default_nettype none
module gpt_sync2 (
    input  wire logic clk_i,     // system clock
    input  wire logic arst_n_i,  // async reset, active low
    input  wire logic d_i,       // raw level
    output logic      q_o        // synchronised level
);
    logic meta_ff;               // first stage, read only by q_o

    // ------------------------------------------------------------
    // two stage register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= 1'b0;
            q_o     <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// [verilog/gpt_prescaler.sv]
// prescale divider: one tick every 1, 8, 64 or 256 input events
// assumes in_i is a one-cycle event strobe on clk_i
`timescale 1ns/10ps
`default_nettype none
module gpt_prescaler
    import gpt_pkg::*;
(
    input  wire logic       clk_i,     // system clock
    input  wire logic       arst_n_i,  // async reset, active low
    input  wire logic       clr_i,     // synchronous clear of the divider
    input  wire logic       in_i,      // input event
    input  wire logic [1:0] sel_i,     // prescale_select
    output logic            tick_o     // one-cycle prescaled tick
);
    logic [7:0] cnt_ff;               // divider state
    logic [7:0] tc;                   // terminal count for sel_i
    logic       at_tc;                // divider at terminal count

    // ratio decode
    assign tc = (sel_i == 2'h0) ? GPT_PS_TC_1  :
                (sel_i == 2'h1) ? GPT_PS_TC_8  :
                (sel_i == 2'h2) ? GPT_PS_TC_64 : GPT_PS_TC_256;
    assign at_tc = (cnt_ff >= tc);

    // ------------------------------------------------------------
    // divider and tick
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= 8'h00;
            tick_o <= 1'b0;
        end else if (clr_i) begin
            cnt_ff <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= in_i && at_tc;
            if (in_i) begin
                cnt_ff <= at_tc ? 8'h00 : cnt_ff + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/gpt_timer.sv]
// 16-bit general-purpose timer/counter with wishbone register slave
// assumes one 50 MHz clock; ext pin and low-power osc are asynchronous
// Overview of operation
// - timer mode counts cycles, wraps at period
// - sync counter: synchronised ext rising edges
// - async counter: ext rising edges, wrap at period
// - idle_stop halts counting during idle
// - gated mode counts cycles while gate high
// - prescale ratios 1, 8, 64, 256
// - prescaler cleared: count write, enable clear, reset
// - disabled prescaler is cleared, then held
// - control write leaves count untouched
// - sleep counting only async external enabled
// - sleep counting wraps and interrupts
// - match sets sticky flag, software clears
// - gate falling edge also sets flag
// - interrupt forwarded only when enabled
// - rtc mode counts low-power osc edges
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
module gpt_timer
    import gpt_pkg::*;
(
    input  wire logic        clk_i,        // instruction_cycle_clock
    input  wire logic        arst_n_i,     // async reset, active low
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write enable
    input  wire logic [3:0]  wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    output logic [31:0]      wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    input  wire logic        ext_clock_gate_pin_i, // ext clock or gate
    input  wire logic        lp_osc_i,     // low-power rtc oscillator
    input  wire logic        rtc_select_i, // ext source is lp oscillator
    input  wire logic        cpu_idle_i,   // cpu in idle
    input  wire logic        cpu_sleep_i,  // cpu in sleep
    output logic             irq_o         // interrupt request
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] count_value_ff;           // running count
    logic [15:0] period_value_ff;          // match value
    logic [15:0] timer_control_ff;         // control bits
    logic        period_int_flag_ff;       // sticky flag
    logic        period_int_enable_ff;     // interrupt enable
    logic        pin_s;                    // synchronised pin
    logic        osc_s;                    // synchronised osc
    logic        pin_d_ff;                 // pin history
    logic        osc_d_ff;                 // osc history
    logic        on_d_ff;                  // count_enable history
    logic        tick;                     // prescaled tick

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire         bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         bus_wr    = bus_req && wb_we_i;
    wire         hit_count = (wb_adr_i == GPT_OFS_COUNT);
    wire         hit_per   = (wb_adr_i == GPT_OFS_PERIOD);
    wire         hit_ctrl  = (wb_adr_i == GPT_OFS_CONTROL);
    wire         hit_int   = (wb_adr_i == GPT_OFS_INT);
    wire         wr_lo     = bus_wr && wb_sel_i[0];
    wire         wr_hi     = bus_wr && wb_sel_i[1];
    wire         wr_count  = (wr_lo || wr_hi) && hit_count;

    // byte-lane merges
    wire [15:0]  wdat_count = {wr_hi ? wb_dat_i[15:8] : count_value_ff[15:8],
                               wr_lo ? wb_dat_i[7:0]  : count_value_ff[7:0]};
    wire [15:0]  wdat_per   = {wr_hi ? wb_dat_i[15:8] : period_value_ff[15:8],
                               wr_lo ? wb_dat_i[7:0]  : period_value_ff[7:0]};
    wire [15:0]  wdat_ctrl  = {wr_hi ? wb_dat_i[15:8] : timer_control_ff[15:8],
                               wr_lo ? wb_dat_i[7:0]  : timer_control_ff[7:0]}
                              & GPT_CTRL_MASK;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire         count_enable           = timer_control_ff[GPT_BIT_ON];
    wire         idle_stop              = timer_control_ff[GPT_BIT_SIDL];
    wire         gate_accumulate_enable = timer_control_ff[GPT_BIT_GATE];
    wire [1:0]   prescale_select        = timer_control_ff[GPT_BIT_PS_HI:GPT_BIT_PS_LO];
    wire         ext_clock_sync         = timer_control_ff[GPT_BIT_SYNC];
    wire         clock_source_select    = timer_control_ff[GPT_BIT_CS];

    // mode selection
    wire gpt_src_t mode = gpt_src_t'(!clock_source_select ?
                          (gate_accumulate_enable ? GPT_SRC_GATED : GPT_SRC_TIMER) :
                          (ext_clock_sync ? GPT_SRC_SYNC : GPT_SRC_ASYNC));

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    gpt_sync2 u_sync_pin (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (ext_clock_gate_pin_i),
        .q_o      (pin_s)
    );

    gpt_sync2 u_sync_osc (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      (lp_osc_i),
        .q_o      (osc_s)
    );

    // edge detection on the synchronised sources
    wire         ext_lvl   = rtc_select_i ? osc_s : pin_s;
    wire         ext_prev  = rtc_select_i ? osc_d_ff : pin_d_ff;
    wire         ext_rise  = ext_lvl && !ext_prev;
    wire         gate_fall = !pin_s && pin_d_ff;

    // ------------------------------------------------------------
    // run conditions
    // ------------------------------------------------------------
    wire         idle_hold  = cpu_idle_i && idle_stop;
    wire         sleep_ok   = count_enable && clock_source_select
                              && !ext_clock_sync;
    wire         sleep_hold = cpu_sleep_i && !sleep_ok;
    wire         run        = count_enable && !idle_hold && !sleep_hold;

    // raw input event per mode
    logic        raw_evt;
    always_comb begin
        unique case (mode)
            GPT_SRC_TIMER: raw_evt = 1'b1;
            GPT_SRC_GATED: raw_evt = pin_s;
            GPT_SRC_SYNC:  raw_evt = ext_rise;
            GPT_SRC_ASYNC: raw_evt = ext_rise;
        endcase
    end

    // clear on count write, enable falling, reset; held while off
    wire         ps_clr = wr_count || (on_d_ff && !count_enable);

    gpt_prescaler u_ps (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .clr_i    (ps_clr),
        .in_i     (raw_evt && run),
        .sel_i    (prescale_select),
        .tick_o   (tick)
    );

    // match and flag events
    wire         at_match  = (count_value_ff == period_value_ff);
    wire         cnt_step  = tick && run;
    wire         match_evt = cnt_step && at_match;
    wire         gate_evt  = gate_fall && count_enable
                             && (mode == GPT_SRC_GATED);
    wire         flag_set  = match_evt || gate_evt;
    wire         flag_clr  = wr_lo && hit_int && !wb_dat_i[GPT_BIT_IF];

    // ------------------------------------------------------------
    // history registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_d_ff <= 1'b0;
            osc_d_ff <= 1'b0;
            on_d_ff  <= 1'b0;
        end else begin
            pin_d_ff <= pin_s;
            osc_d_ff <= osc_s;
            on_d_ff  <= count_enable;
        end
    end

    // ------------------------------------------------------------
    // count register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_value_ff <= GPT_RST_COUNT;
        end else if (wr_count) begin
            count_value_ff <= wdat_count;
        end else if (cnt_step) begin
            count_value_ff <= at_match ? GPT_RST_COUNT
                                       : count_value_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // period and control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period_value_ff  <= GPT_RST_PERIOD;
            timer_control_ff <= GPT_RST_CONTROL;
        end else begin
            if ((wr_lo || wr_hi) && hit_per) begin
                period_value_ff <= wdat_per;
            end
            if ((wr_lo || wr_hi) && hit_ctrl) begin
                timer_control_ff <= wdat_ctrl;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt flag and enable; set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            period_int_flag_ff   <= 1'b0;
            period_int_enable_ff <= 1'b0;
        end else begin
            if (flag_set) begin
                period_int_flag_ff <= 1'b1;
            end else if (flag_clr) begin
                period_int_flag_ff <= 1'b0;
            end
            if (wr_lo && hit_int) begin
                period_int_enable_ff <= wb_dat_i[GPT_BIT_IE];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (period_int_flag_ff || flag_set)
                     && period_int_enable_ff;
        end
    end

    // ------------------------------------------------------------
    // read mux and acknowledge
    // ------------------------------------------------------------
    wire [31:0]  rd_mux = hit_count ? {16'h0000, count_value_ff}   :
                          hit_per   ? {16'h0000, period_value_ff}  :
                          hit_ctrl  ? {16'h0000, timer_control_ff} :
                          hit_int   ? {30'h0, period_int_enable_ff,
                                       period_int_flag_ff}         : 32'h00000000;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// [verif/gpt_props.sv]
// checker for the timer register bus and interrupt output
// assumes it is bound onto gpt_timer and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module gpt_props
    import gpt_pkg::*;
(
    input  wire logic        clk_i,     // system clock
    input  wire logic        arst_n_i,  // async reset, active low
    input  wire logic        wb_cyc_i,  // bus cycle
    input  wire logic        wb_stb_i,  // bus strobe
    input  wire logic        wb_we_i,   // bus write
    input  wire logic [3:0]  wb_adr_i,  // bus address
    input  wire logic [3:0]  wb_sel_i,  // byte selects
    input  wire logic [31:0] wb_dat_i,  // write data
    input  wire logic [31:0] wb_dat_o,  // read data
    input  wire logic        wb_ack_o,  // acknowledge
    input  wire logic        irq_o      // interrupt request
);
    // ----------------------------------------
    // request decode and enable shadow
    // ----------------------------------------
    wire  logic take_w  = wb_cyc_i & wb_stb_i & ~wb_ack_o;       // request taken
    wire  logic rd_w    = wb_ack_o & ~wb_we_i;                    // read answered
    wire  logic ie_wr_w = take_w & wb_we_i & wb_sel_i[0] & (wb_adr_i == GPT_OFS_INT);
    logic       ie_ff;                                            // enable as written

    default clocking dflt_cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // shadow tracks the last written interrupt enable
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ie_ff <= 1'b0;
        end else if (ie_wr_w) begin
            ie_ff <= wb_dat_i[GPT_BIT_IE];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    ack_next_cycle_a: assert property (take_w |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    upper_half_zero_a: assert property (rd_w |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    ctrl_read_mask_a: assert property (rd_w && wb_adr_i == GPT_OFS_CONTROL |-> (wb_dat_o[15:0] & ~GPT_CTRL_MASK) == 16'h0)
        else $error("control reads unwritable bits");
    unmapped_read_a: assert property (rd_w && wb_adr_i[1:0] != 2'b00 |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    irq_masked_a: assert property (irq_o |-> ie_ff || $past(ie_ff))
        else $error("interrupt while disabled");
    irq_from_flag_a: assert property (rd_w && wb_adr_i == GPT_OFS_INT && wb_dat_o[1:0] == 2'b11 |-> ##[0:2] irq_o)
        else $error("flag and enable set without interrupt");
endmodule
bind gpt_timer gpt_props chk_u (.clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);
`default_nettype wire

// [verif/gpt_pin_model.sv]
// model of the external clock, gate pin and low-power oscillator
// assumes edges are paced by the system clock; lines rest low
`timescale 1ns/10ps
`default_nettype none
module gpt_pin_model (
    input  wire logic clk_i,  // pacing clock
    output logic      pin_o,  // ext clock or gate pin
    output logic      osc_o   // low-power oscillator
);
    // both lines rest low between bursts
    initial begin
        pin_o = 1'b0;
        osc_o = 1'b0;
    end

    // n rising edges, each level held w cycles (w=1 prompt)
    task automatic pulses(input int n, input int w, input bit osc);
        for (int i = 0; i < n; i++) begin
            repeat (w) @(posedge clk_i);
            if (osc) osc_o <= 1'b1; else pin_o <= 1'b1;
            repeat (w) @(posedge clk_i);
            if (osc) osc_o <= 1'b0; else pin_o <= 1'b0;
        end
    endtask

    // gate high for h cycles, then low
    task automatic gate(input int h);
        @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (h) @(posedge clk_i);
        pin_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench for the 16-bit timer/counter
// assumes gpt_timer, gpt_props bound to it, and gpt_pin_model
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import gpt_pkg::*;
;
    typedef struct {bit we; logic [3:0] adr; logic [15:0] dat; logic [15:0] exp;} gpt_row_t;
    logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h3;                 // bus request
    logic [31:0] dat_w = 32'h0, dat_r;                    // bus data
    logic        ack, irq, pin, osc;                      // design and model outputs
    logic        rtc = 1'b0, idle = 1'b0, slp = 1'b0;     // mode levels
    logic [15:0] q, c;                                    // read results
    int          num_errors = 0, samples_checked = 0;     // tallies
    gpt_row_t    rows[15] = '{'{0, GPT_OFS_COUNT, 0, 16'h0}, '{0, GPT_OFS_PERIOD, 0, 16'hffff},
        '{0, GPT_OFS_CONTROL, 0, 16'h0}, '{0, GPT_OFS_INT, 0, 16'h0}, '{1, GPT_OFS_PERIOD, 16'h1234, 0},
        '{0, GPT_OFS_PERIOD, 0, 16'h1234}, '{1, GPT_OFS_CONTROL, 16'h7fff, 0}, '{0, GPT_OFS_CONTROL, 0, 16'h2076},
        '{1, GPT_OFS_CONTROL, 0, 0}, '{0, 4'h2, 0, 0}, '{1, GPT_OFS_INT, 16'h3, 0}, '{0, GPT_OFS_INT, 0, 16'h2},
        '{1, GPT_OFS_INT, 0, 0}, '{1, GPT_OFS_COUNT, 16'habcd, 0}, '{0, GPT_OFS_COUNT, 0, 16'habcd}};

    always #10 clk = ~clk;  // 50 MHz

    gpt_timer dut_u (.clk_i(clk), .arst_n_i(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .ext_clock_gate_pin_i(pin), .lp_osc_i(osc), .rtc_select_i(rtc), .cpu_idle_i(idle),
        .cpu_sleep_i(slp), .irq_o(irq));
    gpt_pin_model pin_u (.clk_i(clk), .pin_o(pin), .osc_o(osc));

    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    // one classic cycle, held until ack, then one idle cycle
    task automatic wb(input bit w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        r = dat_r[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
        logic [15:0] r;
        wb(1'b0, a, 16'h0, r);
        chk16(n, e, r);
    endtask
    // set control, send n edges of width w, let them settle
    task automatic ext(input logic [15:0] ctl, input int n, input int w);
        wb(1'b1, GPT_OFS_CONTROL, ctl, q);
        pin_u.pulses(n, w, rtc);
        repeat (8) @(posedge clk);
    endtask
    task automatic clr;
        wb(1'b1, GPT_OFS_COUNT, 16'h0, q);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            wb(rows[i].we, rows[i].adr, rows[i].dat, q);
            if (!rows[i].we) chk16("reg", rows[i].exp, q);
        end
        sel <= 4'h1;
        wb(1'b1, GPT_OFS_PERIOD, 16'hbeef, q);
        sel <= 4'h3;
        rdc("lane", GPT_OFS_PERIOD, 16'h12ef);
        wb(1'b1, GPT_OFS_PERIOD, 16'h0004, q);
        clr();
        wb(1'b1, GPT_OFS_CONTROL, 16'h8000, q);
        repeat (20) @(posedge clk);
        rdc("flag", GPT_OFS_INT, 16'h0001);
        wb(1'b1, GPT_OFS_CONTROL, 16'h0000, q);
        wb(1'b0, GPT_OFS_COUNT, 16'h0, c);
        chk1("wrap", 1'b1, c <= 16'h0004);
        wb(1'b1, GPT_OFS_COUNT, 16'h0055, q);
        wb(1'b1, GPT_OFS_CONTROL, 16'h0030, q);
        rdc("hold", GPT_OFS_COUNT, 16'h0055);
        wb(1'b1, GPT_OFS_PERIOD, 16'hffff, q);
        for (int k = 0; k < 4; k++) begin
            clr();
            ext({8'h80, 2'b00, k[1:0], 4'h2}, 3 << ((k == 3) ? 8 : 3 * k), 1);
            rdc("ratio", GPT_OFS_COUNT, 16'h0003);
        end
        clr();
        ext(16'h8006, 5, 3);
        rdc("sync", GPT_OFS_COUNT, 16'h0005);
        clr();
        ext(16'h8012, 5, 1);
        ext(16'h0012, 0, 1);
        ext(16'h8012, 5, 1);
        rdc("ps_off", GPT_OFS_COUNT, 16'h0000);
        clr();
        ext(16'h8012, 5, 1);
        rdc("ps_wr", GPT_OFS_COUNT, 16'h0000);
        clr();
        idle <= 1'b1;
        ext(16'ha002, 4, 3);
        rdc("idle", GPT_OFS_COUNT, 16'h0000);
        idle <= 1'b0;
        ext(16'ha002, 4, 3);
        rdc("resume", GPT_OFS_COUNT, 16'h0004);
        idle <= 1'b1;
        ext(16'h8002, 4, 3);
        rdc("idle_run", GPT_OFS_COUNT, 16'h0008);
        idle <= 1'b0;
        clr();
        slp <= 1'b1;
        ext(16'h8006, 4, 3);
        rdc("slp_sync", GPT_OFS_COUNT, 16'h0000);
        ext(16'h8002, 4, 3);
        rdc("slp_async", GPT_OFS_COUNT, 16'h0004);
        wb(1'b1, GPT_OFS_PERIOD, 16'h0002, q);
        clr();
        wb(1'b1, GPT_OFS_INT, 16'h0002, q);
        ext(16'h8002, 3, 3);
        rdc("slp_wrap", GPT_OFS_COUNT, 16'h0000);
        rdc("slp_flag", GPT_OFS_INT, 16'h0003);
        chk1("irq", 1'b1, irq);
        wb(1'b1, GPT_OFS_INT, 16'h0002, q);
        repeat (3) @(posedge clk);
        chk1("irq_clr", 1'b0, irq);
        wb(1'b1, GPT_OFS_INT, 16'h0000, q);
        ext(16'h8002, 3, 3);
        rdc("masked", GPT_OFS_INT, 16'h0001);
        chk1("irq_off", 1'b0, irq);
        slp <= 1'b0;
        wb(1'b1, GPT_OFS_PERIOD, 16'hffff, q);
        wb(1'b1, GPT_OFS_CONTROL, 16'h8040, q);
        clr();
        wb(1'b1, GPT_OFS_INT, 16'h0000, q);
        pin_u.gate(10);
        repeat (8) @(posedge clk);
        wb(1'b0, GPT_OFS_COUNT, 16'h0, c);
        chk1("gated", 1'b1, c >= 16'd8 && c <= 16'd12);
        rdc("gate_flag", GPT_OFS_INT, 16'h0001);
        rtc <= 1'b1;
        clr();
        ext(16'h8002, 3, 3);
        rdc("rtc", GPT_OFS_COUNT, 16'h0003);
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rdc("rst_per", GPT_OFS_PERIOD, 16'hffff);
        rdc("rst_ctl", GPT_OFS_CONTROL, 16'h0000);
        rdc("rst_cnt", GPT_OFS_COUNT, 16'h0000);
        rdc("rst_int", GPT_OFS_INT, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
